// *** sgp_host_ctrl.sv ***
`timescale 1ns/1ps
`include "sgp_consts.svh"
module sgp_host_ctrl
  import sgp_pkg::*;
#(
  parameter int HV_SETUP_CYC = `SGP_HV_SETUP_CYC,
  parameter int PROT_CYC = `SGP_PROT_CYC,
  parameter int UNPROT_CYC = `SGP_UNPROT_CYC,
  parameter int MAX_PULSES = `SGP_MAX_PULSES,
  parameter int BUS_CYC = `SGP_BUS_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // user command
  input wire logic cmdStart,
  input wire logic [1:0] cmdOp,
  input wire logic topBoot,
  input wire logic [8:0] groupMask,
  input wire logic tempDone,
  output logic busy,
  output logic cmdDone,
  output logic cmdFail,
  output logic [3:0] failGroup,
  output logic tempActive,
  // flash pins
  output logic highVoltageLevel,
  output logic flashCe_n,
  output logic flashOe_n,
  output logic flashWe_n,
  output logic [19:0] flashAddr,
  output logic [7:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [7:0] flashDqIn
);
  typedef enum logic [3:0] {
    S_IDLE, S_HV, S_NEXT, S_PULSE, S_WAIT, S_VFY, S_READ, S_CHECK, S_TEMP,
    S_DROP, S_RESET, S_END
  } sgp_st_e;

  sgp_st_e st_reg, st_next;
  sgp_op_e op_reg, op_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [4:0] pulseCounter_reg, pulseCounter_next;
  logic [3:0] grp_reg, grp_next;
  logic [8:0] mask_reg, mask_next;
  logic top_reg, top_next;
  logic hv_reg, hv_next;
  logic done_reg, done_next;
  logic fail_reg, fail_next;
  logic [3:0] fgrp_reg, fgrp_next;
  logic busStart, busRead, busDone;
  logic [7:0] busWr, busRd;
  logic [19:0] busAddr;
  logic [6:0] grpBits;

  // group base address bits 18..12 for each coded group
  function automatic logic [6:0] group_bits(input logic top, input logic [3:0] g);
    logic [6:0] r;
    r = 7'h00;
    if (top) begin
      case (g)
        4'd0: r = 7'h00;
        4'd1: r = 7'h20;
        4'd2: r = 7'h40;
        4'd3: r = 7'h60;
        4'd4: r = 7'h70;
        4'd5: r = 7'h78;
        4'd6: r = 7'h7c;
        4'd7: r = 7'h7d;
        default: r = 7'h7e;
      endcase
    end else begin
      case (g)
        4'd0: r = 7'h00;
        4'd1: r = 7'h02;
        4'd2: r = 7'h03;
        4'd3: r = 7'h04;
        4'd4: r = 7'h08;
        4'd5: r = 7'h10;
        4'd6: r = 7'h20;
        4'd7: r = 7'h40;
        default: r = 7'h60;
      endcase
    end
    return r;
  endfunction

  assign grpBits = group_bits(top_reg, grp_reg);
  // byte-mode address: bits 18..12 group, bit six selects unprotect, low pattern
  always_comb begin
    busAddr = {1'b0, grpBits, 12'h000};
    busAddr[6:0] = `SGP_LOW_PAT;
    busAddr[`SGP_ADDR_BIT_SIX] = (op_reg == SGP_OP_UNPROTECT);
    if (st_reg == S_RESET) begin
      busAddr = 20'h00000;
    end
  end
  assign busRead = (st_reg == S_READ);
  assign busWr = (st_reg == S_PULSE) ? `SGP_CMD_PULSE :
                 (st_reg == S_VFY) ? `SGP_CMD_VERIFY : `SGP_CMD_RESET;

  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    tmr_next = tmr_reg;
    pulseCounter_next = pulseCounter_reg;
    grp_next = grp_reg;
    mask_next = mask_reg;
    top_next = top_reg;
    hv_next = hv_reg;
    done_next = 1'b0;
    fail_next = fail_reg;
    fgrp_next = fgrp_reg;
    busStart = 1'b0;
    case (st_reg)
      S_IDLE: begin
        if (cmdStart) begin
          op_next = sgp_op_e'(cmdOp);
          top_next = topBoot;
          // unprotect first protects every group
          mask_next = (cmdOp == 2'(SGP_OP_PROTECT)) ? groupMask : 9'h1ff;
          fail_next = 1'b0;
          grp_next = 4'd0;
          hv_next = 1'b1;
          tmr_next = 32'd0;
          st_next = (cmdOp == 2'(SGP_OP_TEMP)) ? S_TEMP : S_HV;
          if (cmdOp == 2'(SGP_OP_UNPROTECT)) begin
            op_next = SGP_OP_PROTECT;
          end
          unique0 case (cmdOp)
            2'(SGP_OP_UNPROTECT): fgrp_next = 4'hf;
            default: fgrp_next = 4'h0;
          endcase
        end
      end
      S_HV: begin
        tmr_next = tmr_reg + 32'd1;
        if (tmr_reg >= 32'(HV_SETUP_CYC - 1)) begin
          st_next = S_NEXT;
        end
      end
      S_NEXT: begin
        // unprotect retries come back here and must keep their count
        if (op_reg == SGP_OP_PROTECT) begin
          pulseCounter_next = 5'd1;
        end
        if (grp_reg == 4'(`SGP_TOP_GROUPS)) begin
          if (op_reg == SGP_OP_PROTECT && fgrp_reg == 4'hf) begin
            op_next = SGP_OP_UNPROTECT;
            fgrp_next = 4'h0;
            grp_next = 4'd0;
          end else begin
            st_next = S_DROP;
          end
        end else if (!mask_reg[grp_reg] && op_reg == SGP_OP_PROTECT) begin
          grp_next = grp_reg + 4'd1;
        end else if (op_reg == SGP_OP_UNPROTECT && grp_reg != 4'd0) begin
          st_next = S_VFY; // unprotect pulse covers all; verify each group
        end else begin
          st_next = S_PULSE;
        end
      end
      S_PULSE: begin
        busStart = !busDone;
        if (busDone) begin
          tmr_next = 32'd0;
          st_next = S_WAIT;
        end
      end
      S_WAIT: begin
        tmr_next = tmr_reg + 32'd1;
        if ((op_reg == SGP_OP_PROTECT && tmr_reg >= 32'(PROT_CYC - 1)) ||
            (op_reg == SGP_OP_UNPROTECT && tmr_reg >= 32'(UNPROT_CYC - 1))) begin
          st_next = S_VFY;
        end
      end
      S_VFY: begin
        busStart = !busDone;
        if (busDone) begin
          st_next = S_READ;
        end
      end
      S_READ: begin
        busStart = !busDone;
        if (busDone) begin
          st_next = S_CHECK;
        end
      end
      S_CHECK: begin
        if ((op_reg == SGP_OP_PROTECT && busRd == `SGP_RD_PROT) ||
            (op_reg == SGP_OP_UNPROTECT && busRd == `SGP_RD_UNPROT)) begin
          grp_next = grp_reg + 4'd1;
          st_next = S_NEXT;
          if (op_reg == SGP_OP_UNPROTECT) begin
            pulseCounter_next = 5'd1;
          end
        end else if (pulseCounter_reg >= 5'(MAX_PULSES)) begin
          fail_next = 1'b1;
          fgrp_next = grp_reg;
          st_next = S_DROP;
        end else begin
          pulseCounter_next = pulseCounter_reg + 5'd1;
          st_next = (op_reg == SGP_OP_UNPROTECT) ? S_NEXT : S_PULSE;
          if (op_reg == SGP_OP_UNPROTECT) begin
            grp_next = 4'd0;
          end
        end
      end
      S_TEMP: begin
        if (tempDone) begin
          hv_next = 1'b0;
          st_next = S_END;
        end
      end
      S_DROP: begin
        hv_next = 1'b0;
        st_next = S_RESET;
      end
      S_RESET: begin
        busStart = !busDone;
        if (busDone) begin
          st_next = S_END;
        end
      end
      default: begin
        done_next = 1'b1;
        st_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= S_IDLE;
      op_reg <= SGP_OP_PROTECT;
      tmr_reg <= 32'd0;
      pulseCounter_reg <= 5'd1;
      grp_reg <= 4'd0;
      mask_reg <= 9'h000;
      top_reg <= 1'b0;
      hv_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      fgrp_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      tmr_reg <= tmr_next;
      pulseCounter_reg <= pulseCounter_next;
      grp_reg <= grp_next;
      mask_reg <= mask_next;
      top_reg <= top_next;
      hv_reg <= hv_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      fgrp_reg <= fgrp_next;
    end
  end

  sgp_bus_cycle #(.CYC(BUS_CYC)) u_bus (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(busStart),
    .isRead(busRead),
    .addrIn(busAddr),
    .dataIn(busWr),
    .done(busDone),
    .rdData(busRd),
    .flashCe_n(flashCe_n),
    .flashOe_n(flashOe_n),
    .flashWe_n(flashWe_n),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn)
  );

  assign busy = (st_reg != S_IDLE);
  assign cmdDone = done_reg;
  assign cmdFail = fail_reg;
  assign failGroup = fgrp_reg;
  assign tempActive = (st_reg == S_TEMP);
  assign highVoltageLevel = hv_reg;
endmodule

// *** sgp_consts.svh ***
// Overview of operation
// - protect and unprotect use plain bus cycles with clear pin at high voltage.
// - host protects every unprotected group before the first unprotect write.
// - host waits 1 us after raising high voltage before the first write.
// - protect pulse writes 60h with bit six low, then waits 150 us.
// - protect verify writes 40h, reads back, expects 01h.
// - unprotect pulse 60h with bit six high, wait 1.5 ms, verify expects 00h.
// - host counts protect pulses per group, fails at 25 without a pass; each unprotect group pass restarts the count at 1.
`ifndef SGP_CONSTS_SVH
`define SGP_CONSTS_SVH
`define SGP_CLK_NS 4
`define SGP_HV_SETUP_NS 1000
`define SGP_HV_SETUP_CYC ((`SGP_HV_SETUP_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)
`define SGP_PROT_US 150
`define SGP_PROT_CYC ((`SGP_PROT_US * 1000 + `SGP_CLK_NS - 1) / `SGP_CLK_NS)
`define SGP_UNPROT_NS 1500000
`define SGP_UNPROT_CYC ((`SGP_UNPROT_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)
`define SGP_BUS_CYC 25
`define SGP_MAX_PULSES 25
`define SGP_CMD_PULSE 8'h60
`define SGP_CMD_VERIFY 8'h40
`define SGP_CMD_RESET 8'hf0
`define SGP_RD_PROT 8'h01
`define SGP_RD_UNPROT 8'h00
`define SGP_LOW_PAT 7'h02
`define SGP_ADDR_BIT_SIX 6
`define SGP_TOP_GROUPS 9
`define SGP_BOT_GROUPS 9
`endif

// *** sgp_pkg.sv ***
package sgp_pkg;
  typedef enum logic [1:0] {SGP_OP_PROTECT, SGP_OP_UNPROTECT, SGP_OP_TEMP} sgp_op_e;
  typedef enum logic [1:0] {SGP_CYC_IDLE, SGP_CYC_WRITE, SGP_CYC_READ} sgp_cyc_e;
endpackage

// *** sgp_bus_cycle.sv ***
`timescale 1ns/1ps
`include "sgp_consts.svh"
module sgp_bus_cycle
  import sgp_pkg::*;
#(
  parameter int CYC = `SGP_BUS_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // request
  input wire logic start,
  input wire logic isRead,
  input wire logic [19:0] addrIn,
  input wire logic [7:0] dataIn,
  output logic done,
  output logic [7:0] rdData,
  // flash pins
  output logic flashCe_n,
  output logic flashOe_n,
  output logic flashWe_n,
  output logic [19:0] flashAddr,
  output logic [7:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [7:0] flashDqIn
);
  sgp_cyc_e st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [19:0] addr_reg, addr_next;
  logic [7:0] wd_reg, wd_next;
  logic [7:0] rd_reg, rd_next;
  logic done_reg, done_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    case (st_reg)
      SGP_CYC_IDLE: begin
        if (start) begin
          st_next = isRead ? SGP_CYC_READ : SGP_CYC_WRITE;
          cnt_next = 8'h00;
          addr_next = addrIn;
          wd_next = dataIn;
        end
      end
      default: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(CYC - 1)) begin
          if (st_reg == SGP_CYC_READ) begin
            rd_next = flashDqIn;
          end
          done_next = 1'b1;
          st_next = SGP_CYC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= SGP_CYC_IDLE;
      cnt_reg <= 8'h00;
      addr_reg <= 20'h00000;
      wd_reg <= 8'h00;
      rd_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
    end
  end

  // write strobe sits inside the cycle with setup and hold margin; read strobe runs to the cycle end
  assign done = done_reg;
  assign rdData = rd_reg;
  assign flashCe_n = (st_reg == SGP_CYC_IDLE);
  assign flashOe_n = !(st_reg == SGP_CYC_READ && cnt_reg >= 8'h02);
  assign flashWe_n = !(st_reg == SGP_CYC_WRITE && cnt_reg >= 8'h02 &&
                       cnt_reg < 8'(CYC - 2));
  assign flashAddr = addr_reg;
  assign flashDqOut = wd_reg;
  assign flashDqOe = (st_reg == SGP_CYC_WRITE);
endmodule

// *** sgp_chk_properties.sv ***
`timescale 1ns/1ps
module sgp_chk_properties #(
  parameter int HV_SETUP_CYC = 4,
  parameter int PROT_CYC = 20,
  parameter int UNPROT_CYC = 40
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // user side
  input wire logic cmdDone,
  input wire logic tempActive,
  // flash pins
  input wire logic highVoltageLevel,
  input wire logic flashCe_n,
  input wire logic flashOe_n,
  input wire logic flashWe_n,
  input wire logic [19:0] flashAddr,
  input wire logic [7:0] flashDqOut,
  input wire logic flashDqOe
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  int hvCnt;
  int gapCnt;
  logic [1:0] kind;
  // cycles under high voltage, idle gap, last write kind
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hvCnt <= 0;
      gapCnt <= 0;
      kind <= 2'h0;
    end else begin
      hvCnt <= highVoltageLevel ? hvCnt + 1 : 0;
      gapCnt <= flashWe_n ? gapCnt + 1 : 0;
      if (!flashWe_n) begin
        kind <= (flashDqOut != 8'h60) ? 2'h0 : (flashAddr[6] ? 2'h2 : 2'h1);
      end
    end
  end
  sequence sWrStart;
    $fell(flashWe_n);
  endsequence
  sequence sCmdWr;
    !flashWe_n && (flashDqOut == 8'h60 || flashDqOut == 8'h40);
  endsequence
  AST_WR_STROBES: assert property (!flashWe_n |-> !flashCe_n && flashOe_n && flashDqOe)
    else $error("write strobe without select or drive");
  AST_HV_SETUP: assert property (sWrStart ##0 highVoltageLevel |-> hvCnt >= HV_SETUP_CYC)
    else $error("write too soon after high voltage");
  AST_PROT_WAIT: assert property (sWrStart ##0 kind == 2'h1 |-> gapCnt >= PROT_CYC)
    else $error("protect pulse wait too short");
  AST_UNPROT_WAIT: assert property (sWrStart ##0 kind == 2'h2 |-> gapCnt >= UNPROT_CYC)
    else $error("unprotect pulse wait too short");
  AST_CMD_ADDR: assert property (sCmdWr |-> flashAddr[3:0] == 4'h2 && highVoltageLevel)
    else $error("command write with bad low address");
  AST_READ_BUS: assert property (!flashOe_n |-> flashWe_n && !flashDqOe && !flashCe_n)
    else $error("read cycle with bad strobes");
  AST_RESET_CMD: assert property (sWrStart ##0 flashDqOut == 8'hf0 |-> !highVoltageLevel)
    else $error("reset command under high voltage");
  AST_DONE_HV: assert property (cmdDone |-> !highVoltageLevel ##1 !cmdDone)
    else $error("done with high voltage or long pulse");
  AST_TEMP_HV: assert property (tempActive |-> highVoltageLevel)
    else $error("temporary mode without high voltage");
endmodule

bind sgp_host_ctrl sgp_chk_properties #(
  .HV_SETUP_CYC(HV_SETUP_CYC),
  .PROT_CYC(PROT_CYC),
  .UNPROT_CYC(UNPROT_CYC)
) chk (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .cmdDone(cmdDone),
  .tempActive(tempActive),
  .highVoltageLevel(highVoltageLevel),
  .flashCe_n(flashCe_n),
  .flashOe_n(flashOe_n),
  .flashWe_n(flashWe_n),
  .flashAddr(flashAddr),
  .flashDqOut(flashDqOut),
  .flashDqOe(flashDqOe)
);

// *** sgp_flash_model.sv ***
`timescale 1ns/1ps
module sgp_flash_model #(
  parameter realtime HV_NS = 1000.0,
  parameter realtime PROT_NS = 150000.0,
  parameter realtime UNPROT_NS = 1500000.0
) (
  // host pins
  input wire logic highVoltageLevel,
  input wire logic flashCe_n,
  input wire logic flashOe_n,
  input wire logic flashWe_n,
  input wire logic [19:0] flashAddr,
  input wire logic [7:0] flashDqOut,
  input wire logic flashDqOe,
  output logic [7:0] flashDqIn,
  // part option and fault
  input wire logic topBoot,
  input wire logic stuck,
  input wire logic wpLow,
  // observation
  output logic [8:0] protState,
  output logic [8:0] progOk,
  output int violations,
  output int pulses
);
  realtime hvRise = 0.0;
  realtime readyAt = 0.0;
  logic armed = 1'b0;
  int grpSel = 0;
  logic [7:0] lastVal = 8'h00;
  logic [7:0] rdVal;
  logic [8:0] keep;
  initial begin
    protState = 9'h000;
    violations = 0;
    pulses = 0;
  end
  function automatic int grp(input logic top, input logic [6:0] a);
    if (top) begin
      casez (a)
        7'b00?????: return 0;
        7'b01?????: return 1;
        7'b10?????: return 2;
        7'b110????: return 3;
        7'b1110???: return 4;
        7'b11110??: return 5;
        7'b1111100: return 6;
        7'b1111101: return 7;
        default: return 8;
      endcase
    end
    casez (a)
      7'b000000?: return 0;
      7'b0000010: return 1;
      7'b0000011: return 2;
      7'b00001??: return 3;
      7'b0001???: return 4;
      7'b001????: return 5;
      7'b01?????: return 6;
      7'b10?????: return 7;
      default: return 8;
    endcase
  endfunction
  assign rdVal = armed ? {7'h00, protState[grpSel]} : 8'hff;
  // groups open to program and erase; high voltage opens all but guarded ends
  assign keep = wpLow ? (topBoot ? 9'h180 : 9'h003) : 9'h000;
  assign progOk = ~protState | (highVoltageLevel ? ~keep : 9'h000);
  assign flashDqIn = flashDqOe ? flashDqOut : (!flashCe_n && !flashOe_n) ? rdVal : ~lastVal;
  always @(posedge flashOe_n) lastVal = rdVal;
  always @(posedge highVoltageLevel) hvRise = $realtime;
  // timing of host writes under high voltage
  always @(negedge flashWe_n) begin
    if (highVoltageLevel && ($realtime - hvRise < HV_NS || $realtime < readyAt)) begin
      violations++;
    end
  end
  always @(posedge flashWe_n) begin
    armed = 1'b0;
    if (highVoltageLevel && flashAddr[3:0] == 4'h2) begin
      grpSel = grp(topBoot, flashAddr[18:12]);
      armed = (flashDqOut == 8'h40);
      if (flashDqOut == 8'h60 && !flashAddr[6]) begin
        pulses++;
        readyAt = $realtime + PROT_NS;
        if (!stuck) protState[grpSel] = 1'b1;
      end
      if (flashDqOut == 8'h60 && flashAddr[6]) begin
        if (protState !== 9'h1ff) violations++;
        readyAt = $realtime + UNPROT_NS;
        protState = 9'h000;
      end
    end
  end
endmodule

// *** sgp_host_ctrl_tb.sv ***
`timescale 1ns/1ps
module sgp_host_ctrl_tb;
  import sgp_pkg::*;
  logic sysClk = 1'b0;
  logic arst_n = 1'b0;
  logic cmdStart = 1'b0;
  logic [1:0] cmdOp = 2'h0;
  logic topBoot = 1'b1;
  logic [8:0] groupMask = 9'h000;
  logic tempDone = 1'b0;
  logic stuck = 1'b0;
  logic wpLow = 1'b0;
  logic [8:0] tempOpen = 9'h1ff;
  logic busy, cmdDone, cmdFail, tempActive, highVoltageLevel, ce, oe, we, dqOe;
  logic [3:0] failGroup;
  logic [19:0] addr;
  logic [7:0] dqOut, dqIn;
  logic [8:0] protState, progOk;
  int violations, pulses, p0;
  int mismatches = 0;
  int totalChecks = 0;
  int cycles = 0;
  sgp_host_ctrl #(.HV_SETUP_CYC(4), .PROT_CYC(20), .UNPROT_CYC(40)) DUT (
    .sys_clk(sysClk), .arst_n(arst_n), .cmdStart(cmdStart), .cmdOp(cmdOp),
    .topBoot(topBoot), .groupMask(groupMask), .tempDone(tempDone), .busy(busy),
    .cmdDone(cmdDone), .cmdFail(cmdFail), .failGroup(failGroup), .tempActive(tempActive),
    .highVoltageLevel(highVoltageLevel), .flashCe_n(ce), .flashOe_n(oe), .flashWe_n(we),
    .flashAddr(addr), .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn));
  sgp_flash_model #(.HV_NS(16.0), .PROT_NS(80.0), .UNPROT_NS(160.0)) model (
    .highVoltageLevel(highVoltageLevel), .flashCe_n(ce), .flashOe_n(oe), .flashWe_n(we),
    .flashAddr(addr), .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn),
    .topBoot(topBoot), .stuck(stuck), .protState(protState), .violations(violations),
    .pulses(pulses), .wpLow(wpLow), .progOk(progOk));
  always #2 sysClk = ~sysClk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one command to completion; poke retries a start while busy
  task automatic runOp(input logic [1:0] op, input logic top, input logic [8:0] mask,
                       input bit poke);
    int n;
    n = 0;
    cmdOp = op;
    topBoot = top;
    groupMask = mask;
    cmdStart = 1'b1;
    @(negedge sysClk);
    cmdStart = 1'b0;
    while (cmdDone !== 1'b1 && n < 20000) begin
      @(negedge sysClk);
      n++;
      cmdStart = poke && n == 8;
      if (cmdStart) groupMask = 9'h1ff;
      if (op == 2'h2 && tempActive === 1'b1 && tempDone === 1'b0) begin
        check("hv in temp mode", 1, highVoltageLevel);
        check("open in temp", tempOpen, progOk);
        tempDone = 1'b1;
      end
    end
    check("command done", 1, cmdDone);
    check("idle after done", 0, busy);
    tempDone = 1'b0;
  endtask
  task automatic testProtect();
    check("state after reset", 0, protState);
    runOp(SGP_OP_PROTECT, 1'b1, 9'h105, 1'b1);
    check("top groups", 9'h105, protState);
    check("protect fail flag", 0, cmdFail);
    runOp(SGP_OP_PROTECT, 1'b0, 9'h0a0, 1'b0);
    check("bottom closed", 9'h05a, progOk);
    check("bottom groups", 9'h1a5, protState);
    $display("test protect finished");
  endtask
  task automatic testUnprotect();
    runOp(SGP_OP_UNPROTECT, 1'b0, 9'h000, 1'b0);
    check("groups cleared", 0, protState);
    check("groups open", 9'h1ff, progOk);
    check("unprotect fail flag", 0, cmdFail);
    $display("test unprotect finished");
  endtask
  task automatic testRetry();
    stuck = 1'b1;
    p0 = pulses;
    runOp(SGP_OP_PROTECT, 1'b1, 9'h010, 1'b0);
    check("retry fail flag", 1, cmdFail);
    check("failing group", 4'h4, failGroup);
    check("pulse count", 25, pulses - p0);
    stuck = 1'b0;
    $display("test retry finished");
  endtask
  task automatic testTemp();
    runOp(SGP_OP_PROTECT, 1'b1, 9'h181, 1'b0);
    check("top closed", 9'h07e, progOk);
    tempOpen = 9'h1ff;
    runOp(SGP_OP_TEMP, 1'b1, 9'h000, 1'b0);
    check("hv after temp", 0, highVoltageLevel);
    check("closed again", 9'h07e, progOk);
    wpLow = 1'b1;
    tempOpen = 9'h07f;
    runOp(SGP_OP_TEMP, 1'b1, 9'h000, 1'b0);
    check("guarded closed again", 9'h07e, progOk);
    wpLow = 1'b0;
    check("timing faults", 0, violations);
    $display("test temp finished");
  endtask
  initial begin
    repeat (20) @(negedge sysClk);
    arst_n = 1'b1;
    testProtect();
    testUnprotect();
    testRetry();
    testTemp();
    print_verdict();
  end
endmodule
